// ---- logic/event_flag_cell.sv ----
`timescale 1ns/10ps
`include "sysctl_int_defines.svh"

module event_flag_cell (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      flag_o,
  output logic      flag_next_o
);

  logic flag_reg;
  logic flag_next;

  // Sticky flag, a new event beats a clear in the same cycle
  always_comb begin
    if (set_i) begin
      flag_next = 1'b1;
    end else if (clr_i) begin
      flag_next = 1'b0;
    end else begin
      flag_next = flag_reg;
    end
  end

  // Flag storage, frozen while the clock enable is low
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flag_reg <= `RAW_RESET;
    end else if (ce_i) begin
      flag_reg <= flag_next;
    end
  end

  assign flag_o      = flag_reg;
  assign flag_next_o = ce_i ? flag_next : flag_reg;

  // Event during a clear still leaves the flag set
  a_set_beats_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && set_i) |=> flag_o)
    else $error("event lost against a simultaneous clear");

endmodule // event_flag_cell

// ---- logic/sysctl_int_defines.svh ----
`ifndef SYSCTL_INT_DEFINES_SVH
`define SYSCTL_INT_DEFINES_SVH

// ****************************************
// Event vector geometry
// ****************************************
`define EVT_W              7
`define RSVD_W             25
`define EVT_ZERO           7'h00

// Bit positions shared by raw, mask and masked registers
`define BIT_PLL_LOCK       6
`define BIT_CURRENT_LIMIT  5
`define BIT_BOOT_OSC_FAULT 4
`define BIT_MAIN_OSC_FAULT 3
`define BIT_REGULATOR      2
`define BIT_BROWNOUT       1
`define BIT_PLL_FAULT      0

// ****************************************
// Register map (byte offsets, low 12 bits decoded)
// ****************************************
`define ADDR_LSB           0
`define ADDR_MSB           11
`define OFS_BROWNOUT_CTRL  12'h030
`define OFS_RAW_STATUS     12'h050
`define OFS_INT_MASK       12'h054
`define OFS_MASKED_STATUS  12'h058

// Control register field
`define BIT_BOR_RESET_SEL  0

// ****************************************
// Reset values
// ****************************************
`define MASK_RESET         7'h00
`define RAW_RESET          1'h0
`define CTRL_RESET         1'h0
`define WORD_ZERO          32'h00000000
`define RSVD_ZERO          25'h0000000

// ****************************************
// Bus encodings
// ****************************************
`define HTRANS_ACTIVE_BIT  1
`define HRESP_OKAY         1'h0

`endif

// ---- logic/sysctl_int_pkg.sv ----
`include "sysctl_int_defines.svh"

package sysctl_int_pkg;

  // One bit per system-control event
  typedef logic [`EVT_W-1:0] event_vec_t;

  // Bus data word
  typedef logic [31:0] word_t;

  // Register selected by an address phase
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_CTRL,
    SEL_RAW,
    SEL_MASK,
    SEL_MISC
  } reg_sel_t;

endpackage

// ---- logic/sysctl_interrupt_mask_status.sv ----
`timescale 1ns/10ps
`include "sysctl_int_defines.svh"

module sysctl_interrupt_mask_status (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     ce_i,
  // AHB-Lite slave
  input  wire logic                     hsel_i,
  input  wire logic [31:0]              haddr_i,
  input  wire logic [1:0]               htrans_i,
  input  wire logic                     hwrite_i,
  input  wire logic [2:0]               hsize_i,
  input  wire logic                     hready_i,
  input  wire sysctl_int_pkg::word_t    hwdata_i,
  output sysctl_int_pkg::word_t         hrdata_o,
  output logic                          hreadyout_o,
  output logic                          hresp_o,
  // Event detectors and interrupt request
  input  wire sysctl_int_pkg::event_vec_t event_set_i,
  output logic                          irq_o
);

  import sysctl_int_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  logic       ph_valid_reg;
  logic       ph_valid_next;
  logic       ph_write_reg;
  logic       ph_write_next;
  reg_sel_t   ph_sel_reg;
  reg_sel_t   ph_sel_next;
  logic       addr_take;
  reg_sel_t   addr_sel;
  logic       wr_en;

  event_vec_t mask_reg;
  event_vec_t mask_next;
  logic       bor_sel_reg;
  logic       bor_sel_next;
  event_vec_t clr_vec;
  event_vec_t raw_flags;
  event_vec_t raw_next;
  event_vec_t gate_cur;
  event_vec_t gate_next;
  event_vec_t masked;
  event_vec_t masked_next;

  word_t      hrdata_reg;
  word_t      hrdata_next;
  logic       irq_reg;
  logic       irq_next;

  // ****************************************
  // Bus address phase
  // ****************************************

  // Address decode on the low offset bits
  always_comb begin
    case (haddr_i[`ADDR_MSB:`ADDR_LSB])
      `OFS_BROWNOUT_CTRL: addr_sel = SEL_CTRL;
      `OFS_RAW_STATUS:    addr_sel = SEL_RAW;
      `OFS_INT_MASK:      addr_sel = SEL_MASK;
      `OFS_MASKED_STATUS: addr_sel = SEL_MISC;
      default:            addr_sel = SEL_NONE;
    endcase
  end

  assign addr_take = hsel_i && hready_i && htrans_i[`HTRANS_ACTIVE_BIT];

  // Next address-phase capture
  always_comb begin
    ph_valid_next = addr_take;
    ph_write_next = addr_take && hwrite_i;
    ph_sel_next   = addr_take ? addr_sel : SEL_NONE;
  end

  // Address-phase registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ph_valid_reg <= 1'b0;
      ph_write_reg <= 1'b0;
      ph_sel_reg   <= SEL_NONE;
    end else if (ce_i) begin
      ph_valid_reg <= ph_valid_next;
      ph_write_reg <= ph_write_next;
      ph_sel_reg   <= ph_sel_next;
    end
  end

  // Write takes effect in the data phase
  assign wr_en = ph_valid_reg && ph_write_reg;

  // ****************************************
  // Mask and control registers
  // ****************************************

  // Next mask and brown-out control; reserved bits dropped
  always_comb begin
    mask_next    = mask_reg;
    bor_sel_next = bor_sel_reg;
    if (ce_i && wr_en && (ph_sel_reg == SEL_MASK)) begin
      mask_next = hwdata_i[`EVT_W-1:0];
    end
    if (ce_i && wr_en && (ph_sel_reg == SEL_CTRL)) begin
      bor_sel_next = hwdata_i[`BIT_BOR_RESET_SEL];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mask_reg    <= `MASK_RESET;
      bor_sel_reg <= `CTRL_RESET;
    end else begin
      mask_reg    <= mask_next;
      bor_sel_reg <= bor_sel_next;
    end
  end

  // ****************************************
  // Raw event flags
  // ****************************************

  assign clr_vec = (wr_en && (ph_sel_reg == SEL_MISC)) ? hwdata_i[`EVT_W-1:0] : `EVT_ZERO;

  // One sticky flag per event
  genvar gi;
  generate
    for (gi = 0; gi < `EVT_W; gi = gi + 1) begin : g_flag
      event_flag_cell u_flag (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .ce_i        (ce_i),
        .set_i       (event_set_i[gi]),
        .clr_i       (clr_vec[gi]),
        .flag_o      (raw_flags[gi]),
        .flag_next_o (raw_next[gi])
      );
    end
  endgenerate

  // ****************************************
  // Masked status and interrupt request
  // ****************************************

  always_comb begin
    gate_cur                 = mask_reg;
    gate_next                = mask_next;
    gate_cur[`BIT_BROWNOUT]  = mask_reg[`BIT_BROWNOUT] && !bor_sel_reg;
    gate_next[`BIT_BROWNOUT] = mask_next[`BIT_BROWNOUT] && !bor_sel_next;
  end

  assign masked      = raw_flags & gate_cur;
  assign masked_next = raw_next & gate_next;

  assign irq_next = |masked_next;

  // Interrupt request register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  // ****************************************
  // Read data
  // ****************************************

  // Read data from post-write state, so back-to-back reads see writes
  always_comb begin
    hrdata_next = hrdata_reg;
    if (ce_i && addr_take && !hwrite_i) begin
      case (addr_sel)
        SEL_CTRL: begin
          hrdata_next = `WORD_ZERO;
          hrdata_next[`BIT_BOR_RESET_SEL] = bor_sel_next;
        end
        SEL_RAW:  hrdata_next = {`RSVD_ZERO, raw_next};
        SEL_MASK: hrdata_next = {`RSVD_ZERO, mask_next};
        SEL_MISC: hrdata_next = {`RSVD_ZERO, masked_next};
        default:  hrdata_next = `WORD_ZERO;
      endcase
    end
  end

  // Read data register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hrdata_reg <= `WORD_ZERO;
    end else begin
      hrdata_reg <= hrdata_next;
    end
  end

  // Zero-wait slave, always OKAY
  assign hreadyout_o = 1'b1;
  assign hresp_o     = `HRESP_OKAY;
  assign hrdata_o    = hrdata_reg;
  assign irq_o       = irq_reg;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_i);
  endclocking

  default disable iff (rst_i);

  // Read of a register taken while enabled
  sequence s_read(reg_sel_t s);
    ce_i && addr_take && !hwrite_i && (addr_sel == s);
  endsequence

  // Data phase of a masked status write
  sequence s_misc_write;
    ce_i && wr_en && (ph_sel_reg == SEL_MISC);
  endsequence

  a_pll_lock_gate: assert property (
    (masked[`BIT_PLL_LOCK] == (raw_flags[`BIT_PLL_LOCK] && mask_reg[`BIT_PLL_LOCK]))
    && (!masked[`BIT_PLL_LOCK] || irq_o))
    else $error("PLL lock gating wrong");

  a_current_limit_gate: assert property (
    (masked[`BIT_CURRENT_LIMIT] ==
     (raw_flags[`BIT_CURRENT_LIMIT] && mask_reg[`BIT_CURRENT_LIMIT]))
    && (!masked[`BIT_CURRENT_LIMIT] || irq_o))
    else $error("current limit gating wrong");

  a_boot_osc_gate: assert property (
    (masked[`BIT_BOOT_OSC_FAULT] ==
     (raw_flags[`BIT_BOOT_OSC_FAULT] && mask_reg[`BIT_BOOT_OSC_FAULT]))
    && (!masked[`BIT_BOOT_OSC_FAULT] || irq_o))
    else $error("boot oscillator gating wrong");

  a_main_osc_gate: assert property (
    (masked[`BIT_MAIN_OSC_FAULT] ==
     (raw_flags[`BIT_MAIN_OSC_FAULT] && mask_reg[`BIT_MAIN_OSC_FAULT]))
    && (!masked[`BIT_MAIN_OSC_FAULT] || irq_o))
    else $error("main oscillator gating wrong");

  a_regulator_gate: assert property (
    (masked[`BIT_REGULATOR] == (raw_flags[`BIT_REGULATOR] && mask_reg[`BIT_REGULATOR]))
    && (!masked[`BIT_REGULATOR] || irq_o))
    else $error("regulator gating wrong");

  a_brownout_gate: assert property (
    (!mask_reg[`BIT_BROWNOUT] |-> !masked[`BIT_BROWNOUT])
    and (masked[`BIT_BROWNOUT] |-> irq_o))
    else $error("brown-out gating wrong");

  a_pll_fault_gate: assert property (
    (masked[`BIT_PLL_FAULT] == (raw_flags[`BIT_PLL_FAULT] && mask_reg[`BIT_PLL_FAULT]))
    && (!masked[`BIT_PLL_FAULT] || irq_o))
    else $error("PLL fault gating wrong");

  a_misc_read_value: assert property (
    s_read(SEL_MISC) |=> (hrdata_o == {`RSVD_ZERO, masked}))
    else $error("masked status readout wrong");

  a_w1c_clears_raw: assert property (
    s_misc_write |=>
      ((raw_flags & $past(hwdata_i[`EVT_W-1:0]) & ~$past(event_set_i)) == `EVT_ZERO)
      && ((($past(raw_flags) & ~$past(hwdata_i[`EVT_W-1:0])) & ~raw_flags) == `EVT_ZERO))
    else $error("write-one clear misbehaved");

  a_mask_reserved: assert property (
    s_read(SEL_MASK) |=> (hrdata_o[31:`EVT_W] == `RSVD_ZERO))
    else $error("reserved mask bits not zero");

  a_reset_clean: assert property (@(posedge clk_i)
    $fell(rst_i) |-> (mask_reg == `MASK_RESET) && !irq_o && (masked == `EVT_ZERO))
    else $error("state not clean after reset");

  a_brownout_select: assert property (
    bor_sel_reg |-> !masked[`BIT_BROWNOUT])
    else $error("brown-out reported despite reset select");

  a_irq_level: assert property (
    (|masked) == irq_o)
    else $error("interrupt request disagrees with masked status");

endmodule // sysctl_interrupt_mask_status

// ---- test/event_source_model.sv ----
`timescale 1ns/10ps

module event_source_model (
  input  wire logic                  clk_i,
  output sysctl_int_pkg::event_vec_t event_o
);
  import sysctl_int_pkg::*;

  // Detector outputs idle low
  initial event_o = '0;

  // One-cycle event pulse, launched just after a rising edge
  task automatic pulse(input event_vec_t v);
    event_o <= v;
    @(posedge clk_i);
    event_o <= '0;
  endtask
endmodule // event_source_model

// ---- test/tb_sysctl_interrupt_mask_status.sv ----
`timescale 1ns/10ps

module tb_sysctl_interrupt_mask_status;
  import sysctl_int_pkg::*;

  logic        clk_i;
  logic        rst_i;
  logic        ce;
  logic        hsel;
  logic        hwrite;
  logic        hready;
  logic        hresp;
  logic        irq;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  word_t       hwdata;
  word_t       hrdata;
  event_vec_t  evt;
  int          fail_count;
  int          checked;

  // 200 MHz clock
  initial clk_i = 1'b0;
  always #2.5 clk_i = ~clk_i;

  sysctl_interrupt_mask_status dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hready_i(hready),
    .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .event_set_i(evt), .irq_o(irq)
  );

  event_source_model src (.clk_i(clk_i), .event_o(evt));

  // ****
  // Common tasks
  // ****
  task automatic test_done;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input word_t got, input word_t exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Bounded wait for hready at a rising edge
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (hready !== 1'b1 && n < 64);
    if (hready !== 1'b1) begin
      fail_count++;
      test_done;
    end
  endtask

  task automatic bus_wr(input logic [11:0] a, input word_t d);
    haddr  <= {20'h00000, a};
    htrans <= 2'h2;
    hwrite <= 1'b1;
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= d & 32'h0000007F;
    wait_rdy;
  endtask

  task automatic bus_rd(input logic [11:0] a, output word_t d);
    haddr  <= {20'h00000, a};
    htrans <= 2'h2;
    hwrite <= 1'b0;
    wait_rdy;
    htrans <= 2'h0;
    wait_rdy;
    d = hrdata;
  endtask

  // Interrupt level seen mid-cycle, then back on the edge
  task automatic irq_is(input logic e);
    @(negedge clk_i);
    chk({31'h00000000, irq}, {31'h00000000, e});
    @(posedge clk_i);
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_reset;
    word_t d;
    bus_rd(12'h054, d);
    chk(d, 32'h00000000);
    bus_rd(12'h058, d);
    chk(d, 32'h00000000);
    chk({31'h00000000, irq}, 32'h00000000);
    chk({31'h00000000, hresp}, 32'h00000000);
    bus_rd(12'h100, d);
    chk(d, 32'h00000000);
    $display("t_reset done");
  endtask

  task automatic t_each_bit;
    word_t      d;
    event_vec_t m;
    for (int b = 0; b < 7; b++) begin
      m = event_vec_t'(1 << b);
      bus_wr(12'h054, 32'h00000000);
      src.pulse(m);
      irq_is(1'b0);
      bus_rd(12'h058, d);
      chk(d, 32'h00000000);
      bus_wr(12'h054, {25'h0000000, m});
      irq_is(1'b1);
      bus_rd(12'h058, d);
      chk(d, {25'h0000000, m});
      bus_wr(12'h058, 32'h00000000);
      bus_rd(12'h050, d);
      chk(d, {25'h0000000, m});
      bus_wr(12'h058, {25'h0000000, m});
      irq_is(1'b0);
      bus_rd(12'h050, d);
      chk(d, 32'h00000000);
    end
    $display("t_each_bit done");
  endtask

  task automatic t_brownout;
    word_t d;
    bus_wr(12'h030, 32'h00000001);
    bus_rd(12'h030, d);
    chk(d, 32'h00000001);
    bus_wr(12'h054, 32'h00000002);
    src.pulse(7'h02);
    irq_is(1'b0);
    bus_rd(12'h058, d);
    chk(d, 32'h00000000);
    bus_wr(12'h030, 32'h00000000);
    irq_is(1'b1);
    bus_wr(12'h058, 32'h00000002);
    $display("t_brownout done");
  endtask

  task automatic t_irq_held;
    word_t d;
    bus_wr(12'h054, 32'h0000007F);
    src.pulse(7'h41);
    bus_wr(12'h058, 32'h00000040);
    irq_is(1'b1);
    bus_rd(12'h058, d);
    chk(d, 32'h00000001);
    bus_wr(12'h058, 32'h00000001);
    irq_is(1'b0);
    $display("t_irq_held done");
  endtask

  // Event offered while the clock enable is low must not be kept
  task automatic t_freeze;
    word_t d;
    ce <= 1'b0;
    src.pulse(7'h10);
    irq_is(1'b0);
    ce <= 1'b1;
    bus_rd(12'h050, d);
    chk(d, 32'h00000000);
    $display("t_freeze done");
  endtask

  // Reset in mid-run clears mask, flags and request
  task automatic t_reset_again;
    word_t d;
    bus_wr(12'h054, 32'h0000007F);
    src.pulse(7'h20);
    irq_is(1'b1);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    irq_is(1'b0);
    bus_rd(12'h054, d);
    chk(d, 32'h00000000);
    bus_rd(12'h058, d);
    chk(d, 32'h00000000);
    bus_rd(12'h050, d);
    chk(d, 32'h00000000);
    $display("t_reset_again done");
  endtask

  // Main sequence
  initial begin
    fail_count = 0;
    checked    = 0;
    rst_i      = 1'b1;
    ce         = 1'b1;
    hsel       = 1'b1;
    haddr      = 32'h00000000;
    htrans     = 2'h0;
    hwrite     = 1'b0;
    hsize      = 3'h2;
    hwdata     = 32'h00000000;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset;
    t_each_bit;
    t_brownout;
    t_irq_held;
    t_freeze;
    t_reset_again;
    test_done;
  end
endmodule // tb_sysctl_interrupt_mask_status
